// File: common/ccb_pkg.sv
// Function
// - separate control block per network
// - global select static or user driven
// - pins on inputs 0-1, plls 2-3
// - static global stage from configuration only
// - regional select fixed by configuration
// - powered-down network gets no edges
// - unused networks off by configuration
// - run-time enable synchronous to network clock
// - gating on network, not pll counters
// - enable captured on falling clock edge
// - optional synchronizer stage, configuration bypass
// - no bypass on external output path
// - enable also gates external output pin
// - gating never disturbs pll feedback
// - external output select from configuration only
// - dual-purpose pin muxes internal or clock
package ccb_pkg;
	localparam int SEL_W      = 2;
	localparam int SRC_N      = 4;
	localparam int PLL_N      = 2;
	localparam int PIN_N      = 2;
	localparam int unsigned CH_N        = 3;
	localparam int unsigned CH_GLOBAL   = 0;
	localparam int unsigned CH_REGIONAL = 1;
	localparam int unsigned CH_EXT      = 2;
	localparam logic [1:0] SEL_PIN0 = 2'h0;
	localparam logic [1:0] SEL_PIN1 = 2'h1;
	localparam logic [1:0] SEL_PLL0 = 2'h2;
	localparam logic [1:0] SEL_PLL1 = 2'h3;
	localparam logic RESET_EN = 1'b0;

	typedef struct packed {
		logic [1:0] pin_clk;
		logic [1:0] pll_clk;
	} ccb_src_s;

	typedef struct packed {
		logic       dynamic_mode;
		logic [1:0] static_select;
		logic [1:0] regional_select;
		logic [1:0] ext_select;
		logic       global_unused;
		logic       regional_unused;
		logic       meta_bypass;
		logic       ext_pin_clock_mode;
	} ccb_cfg_s;
endpackage

// File: design/ccb_clock_control.sv
`timescale 1ns/10ps
`default_nettype none
module ccb_clock_control
	import ccb_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire ccb_src_s   sources,
	input  wire ccb_cfg_s   cfg,
	input  wire logic       user_mode,
	input  wire logic [1:0] network_source_select,
	input  wire logic       global_enable,
	input  wire logic       regional_enable,
	input  wire logic       ext_enable,
	input  wire logic       ext_internal_signal,
	output logic            global_clock_net,
	output logic            regional_clock_net,
	output logic            dedicated_clock_output_pin,
	output logic [1:0]      active_select
);
	// select path of the global network
	logic [SEL_W-1:0]     sel_q;
	logic [SEL_W-1:0]     sel_d;
	logic                 dyn_take;
	logic [SEL_W-1:0]     active_select_d;

	// per-channel view: global, regional, external output
	logic [SEL_W-1:0]     ch_sel [CH_N];
	logic [CH_N-1:0]      ch_src;
	logic [CH_N-1:0]      ch_en_raw;
	logic [CH_N-1:0]      ch_bypass;
	logic [CH_N-1:0]      ch_off;
	wire logic [CH_N-1:0] ch_gated;

	// dual-purpose pin path
	logic                 pin_clock_mode;
	logic                 pin_internal;

	// one of the two pins or two pll outputs
	function automatic logic pick
	(
		input ccb_src_s         s,
		input logic [SEL_W-1:0] sel
	);
		logic r;
		r = 1'b0;
		unique case (sel)
			SEL_PIN0:
			begin
				r = s.pin_clk[0];
			end
			SEL_PIN1:
			begin
				r = s.pin_clk[1];
			end
			SEL_PLL0:
			begin
				r = s.pll_clk[0];
			end
			SEL_PLL1:
			begin
				r = s.pll_clk[1];
			end
		endcase
		return r;
	endfunction

	// source select seen by each channel
	function automatic logic [SEL_W-1:0] chan_select
	(
		input ccb_cfg_s         c,
		input int unsigned      ch,
		input logic [SEL_W-1:0] global_sel
	);
		logic [SEL_W-1:0] r;
		r = c.ext_select;
		if (ch == CH_GLOBAL)
		begin
			r = global_sel;
		end
		else if (ch == CH_REGIONAL)
		begin
			r = c.regional_select;
		end
		else
		begin
			r = c.ext_select;
		end
		return r;
	endfunction

	// channels that configuration switches off for good
	function automatic logic chan_off
	(
		input ccb_cfg_s    c,
		input int unsigned ch
	);
		logic r;
		r = 1'b0;
		if (ch == CH_GLOBAL)
		begin
			r = c.global_unused;
		end
		else if (ch == CH_REGIONAL)
		begin
			r = c.regional_unused;
		end
		return r;
	endfunction

	// external output path always keeps the full register chain
	function automatic logic chan_bypass
	(
		input ccb_cfg_s    c,
		input int unsigned ch
	);
		logic r;
		r = c.meta_bypass;
		if (ch == CH_EXT)
		begin
			r = 1'b0;
		end
		return r;
	endfunction

	// dynamic select only with dynamic mode and user mode
	always_comb
	begin
		dyn_take = cfg.dynamic_mode && user_mode;
	end

	always_comb
	begin
		if (dyn_take)
		begin
			sel_d = network_source_select;
		end
		else
		begin
			sel_d = cfg.static_select;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			sel_q <= SEL_PIN0;
		end
		else
		begin
			sel_q <= sel_d;
		end
	end

	always_comb
	begin
		active_select_d = sel_q;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			active_select <= SEL_PIN0;
		end
		else
		begin
			active_select <= active_select_d;
		end
	end

	// each network has its own select
	always_comb
	begin
		for (int unsigned ch = 0; ch < CH_N; ch++)
		begin
			ch_sel[ch] = chan_select(cfg, ch, sel_q);
		end
	end

	// raw source clock of each channel
	always_comb
	begin
		for (int unsigned ch = 0; ch < CH_N; ch++)
		begin
			ch_src[ch] = pick(sources, ch_sel[ch]);
		end
	end

	always_comb
	begin
		for (int unsigned ch = 0; ch < CH_N; ch++)
		begin
			ch_off[ch] = chan_off(cfg, ch);
		end
	end

	always_comb
	begin
		for (int unsigned ch = 0; ch < CH_N; ch++)
		begin
			ch_bypass[ch] = chan_bypass(cfg, ch);
		end
	end

	always_comb
	begin
		ch_en_raw              = '0;
		ch_en_raw[CH_GLOBAL]   = global_enable;
		ch_en_raw[CH_REGIONAL] = regional_enable;
		ch_en_raw[CH_EXT]      = ext_enable;
	end

	for (genvar ch = 0; ch < CH_N; ch++)
	begin : g_chan
		logic meta_q;
		logic en_in;
		logic en_q;

		// optional metastability stage on the network clock
		always_ff @(posedge ch_src[ch])
		begin
			if (reset)
			begin
				meta_q <= RESET_EN;
			end
			else
			begin
				meta_q <= ch_en_raw[ch];
			end
		end

		always_comb
		begin
			if (ch_bypass[ch])
			begin
				en_in = ch_en_raw[ch];
			end
			else
			begin
				en_in = meta_q;
			end
		end

		// enable taken between pulses, on the falling edge
		always_ff @(negedge ch_src[ch])
		begin
			if (reset)
			begin
				en_q <= RESET_EN;
			end
			else
			begin
				en_q <= en_in && !ch_off[ch];
			end
		end

		// high pulses pass whole or not at all
		assign ch_gated[ch] = ch_src[ch] && en_q;
	end

	// gating acts on the networks and the external output clock only; pll sources pass untouched
	assign global_clock_net   = ch_gated[CH_GLOBAL];
	assign regional_clock_net = ch_gated[CH_REGIONAL];

	always_comb
	begin
		pin_clock_mode = cfg.ext_pin_clock_mode;
		pin_internal   = ext_internal_signal;
	end

	// dual-purpose pin: internal signal or the gated clock
	always_comb
	begin
		if (pin_clock_mode)
		begin
			dedicated_clock_output_pin = ch_gated[CH_EXT];
		end
		else
		begin
			dedicated_clock_output_pin = pin_internal;
		end
	end
endmodule
`default_nettype wire

// File: verif/ccb_chk_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module ccb_chk
	import ccb_pkg::*;
(
	input wire logic       clk,
	input wire logic       reset,
	input wire ccb_cfg_s   cfg,
	input wire logic       user_mode,
	input wire logic [1:0] network_source_select,
	input wire logic       global_enable,
	input wire logic       global_clock_net,
	input wire logic [1:0] active_select
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	property p_dyn;
		cfg.dynamic_mode && user_mode |-> ##2 active_select == $past(network_source_select, 2);
	endproperty
	a_dyn: assert property (p_dyn) else $error("select not followed");
	property p_gate;
		@(negedge clk) !$past(global_enable, 2) && !$past(global_enable, 3) |-> !global_clock_net;
	endproperty
	a_gate: assert property (p_gate) else $error("gated clock ran");
	property p_static;
		!(cfg.dynamic_mode && user_mode) |-> ##2 active_select == $past(cfg.static_select, 2);
	endproperty
	a_static: assert property (p_static) else $error("static select not followed");
	property p_reset_sel;
		@(posedge clk) disable iff (1'b0) reset |=> active_select == SEL_PIN0;
	endproperty
	a_reset_sel: assert property (p_reset_sel) else $error("select not cleared by reset");
	property p_unused;
		@(negedge clk) cfg.global_unused && $past(cfg.global_unused) |-> !global_clock_net;
	endproperty
	a_unused: assert property (p_unused) else $error("unused network ran");
	property p_run;
		@(negedge clk) $past(global_enable) && $past(global_enable, 2) && !$past(cfg.global_unused)
			&& !$past(reset) && !$past(reset, 2) |-> global_clock_net;
	endproperty
	a_run: assert property (p_run) else $error("enabled network stopped");
	cover property (active_select == SEL_PLL1);
	cover property (@(negedge clk) global_clock_net);
	cover property ($fell(global_enable));
endmodule
bind ccb_clock_control ccb_chk i_chk (.clk(clk), .reset(reset), .cfg(cfg), .user_mode(user_mode),
	.network_source_select(network_source_select), .global_enable(global_enable),
	.global_clock_net(global_clock_net), .active_select(active_select));
`default_nettype wire

// File: verif/ccb_user_logic.sv
`timescale 1ns/10ps
`default_nettype none
module ccb_user_logic (
	input  wire logic       clk,
	input  wire logic [1:0] want_sel,
	input  wire logic       want_en,
	output logic [1:0]      network_source_select,
	output logic            enable
);
	always @(posedge clk) {network_source_select, enable} <= #1 {want_sel, want_en};
endmodule
`default_nettype wire

// File: verif/ccb_clock_control_tb.sv
`timescale 1ns/10ps
`default_nettype none
module ccb_clock_control_tb;
	import ccb_pkg::*;
	logic       clk = 0, reset = 1, um = 0, en, want_en = 0, g, r, d, xs = 0;
	logic [1:0] sel, want_sel = 0, act;
	int         n_mismatch = 0, n_tests = 0;
	ccb_cfg_s   cfg = '{1'b1, 2'h0, 2'h0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1};
	initial forever #25 clk = ~clk;
	ccb_user_logic i_usr (.clk(clk), .want_sel(want_sel), .want_en(want_en),
		.network_source_select(sel), .enable(en));
	ccb_clock_control i_dut (.clk(clk), .reset(reset), .sources({4{clk}}), .cfg(cfg),
		.user_mode(um), .network_source_select(sel), .global_enable(en), .regional_enable(en),
		.ext_enable(en), .ext_internal_signal(xs), .global_clock_net(g),
		.regional_clock_net(r), .dedicated_clock_output_pin(d), .active_select(act));
	task chk(input string n, input logic [1:0] e, input logic [1:0] v);
		n_tests++;
		if (v !== e)
		begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", n, e, v);
		end
	endtask
	task test_done;
		if (n_mismatch == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task t_sel;
		for (int s = 0; s < 4; s++)
		begin
			want_sel = s[1:0];
			repeat (3) @(posedge clk);
			#1 chk("active_select", s[1:0], act);
		end
	endtask
	task t_gate(input logic v);
		want_en = v;
		repeat (6) @(posedge clk);
		#1 chk("global_clock_net", {1'b0, v}, {1'b0, g});
		chk("regional_clock_net", {1'b0, v}, {1'b0, r});
		chk("dedicated_clock_output_pin", {1'b0, v}, {1'b0, d});
	endtask
	task t_unused;
		cfg.global_unused = 1'b1;
		repeat (3) @(posedge clk);
		#1 chk("unused_global", 2'h0, {1'b0, g});
		chk("regional_kept", 2'h1, {1'b0, r});
		cfg.global_unused = 1'b0;
		repeat (3) @(posedge clk);
		#1 chk("global_back", 2'h1, {1'b0, g});
	endtask
	task t_static;
		um = 0;
		cfg.static_select = SEL_PLL0;
		repeat (3) @(posedge clk);
		#1 chk("static_select", SEL_PLL0, act);
		cfg.ext_pin_clock_mode = 1'b0;
		xs = 1'b1;
		#1 chk("pin_internal", 2'h1, {1'b0, d});
		cfg.ext_pin_clock_mode = 1'b1;
		xs = 1'b0;
		um = 1;
	endtask
	initial
	begin
		repeat (20) @(posedge clk);
		#1 chk("reset_gate", 2'h0, {1'b0, g});
		reset = 0;
		um = 1;
		t_sel();
		t_gate(1);
		t_gate(0);
		t_gate(1);
		t_unused();
		t_static();
		test_done();
	end
	initial
	begin
		#20000 n_mismatch++;
		test_done();
	end
endmodule
`default_nettype wire
